// ### verilog/special_instruction_execution.v
// special instruction execution logic of a 4-bit core, registers over AXI4-Lite
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "special_exec_map.vh"

module special_instruction_execution #(
  parameter TB_WIDTH = 10
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [10:0] romAddr,
  input  wire [7:0]  romData,
  input  wire        pulseInputHi,
  input  wire        pulseInputLo,
  input  wire        clockPinInput,
  input  wire        serialIn,
  output wire        serialOut,
  output wire        serialClockLatch,
  output wire [7:0]  portOut,
  output wire [7:0]  portOe,
  output wire        idle,
  output wire        busy
);

  // ***************************************
  // state
  // ***************************************
  localparam ST_READY = 2'd0;
  localparam ST_FETCH = 2'd1;
  localparam ST_IDLE  = 2'd2;

  reg [1:0]  state_reg;
  reg [3:0]  op_reg;
  reg [10:0] pc_reg;
  reg [10:0] stackOne_reg;
  reg [10:0] stackTwo_reg;
  reg [10:0] stackThree_reg;
  reg [3:0]  accum_reg;
  reg [3:0]  ramDigit_reg;
  reg [3:0]  serial_reg;
  reg        clkLatch_reg;
  reg [7:0]  lookup_reg;
  reg [7:0]  timer_reg;
  reg        overflow_reg;
  reg [TB_WIDTH-1:0] timeBase_reg;
  reg        latchHi_reg;
  reg        latchLo_reg;
  reg [1:0]  lowHi_reg;
  reg [1:0]  lowLo_reg;
  reg        prevHi_reg;
  reg        prevLo_reg;
  reg [3:0]  ctrl_reg;
  reg [7:0]  portData_reg;
  reg        skip_reg;
  reg [2:0]  cycles_reg;

  reg        awTaken_reg;
  reg        wTaken_reg;
  reg [7:0]  awAddr_reg;
  reg [31:0] wData_reg;

  // ***************************************
  // bus slave: address and data in either order
  // ***************************************
  assign s_axi_awready = !awTaken_reg && !s_axi_bvalid;
  assign s_axi_wready  = !wTaken_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire doWrite = awTaken_reg && wTaken_reg;
  wire opStart = doWrite && (awAddr_reg == `OFS_INSTR) && (state_reg == ST_READY);
  wire [3:0] newOp = wData_reg[3:0];

  assign busy = (state_reg != ST_READY);
  assign idle = (state_reg == ST_IDLE);
  assign serialOut = serial_reg[3];
  assign serialClockLatch = clkLatch_reg;
  assign portOut = portData_reg;
  // pins released when the program drops the enable
  assign portOe = {8{ctrl_reg[`CTRL_PORTEN_BIT]}};

  // pc+1 wraps through page boundaries, so last-word page jumps land in next page; the page-2 call goes to page 2
  wire [10:0] pcNext = pc_reg + 11'h001;
  wire timeBaseCarry = &timeBase_reg;

  // qualified falls: high two samples back, then low for two samples in a row
  // a single low sample is a glitch and must not set the latch
  wire fallHi = (lowHi_reg == 2'b10) && !pulseInputHi;
  wire fallLo = (lowLo_reg == 2'b10) && !pulseInputLo;

  // ***************************************
  // write channel and response
  // ***************************************
  always @(posedge clk) begin
    if (rst) begin
      awTaken_reg  <= 1'b0;
      wTaken_reg   <= 1'b0;
      awAddr_reg   <= 8'h00;
      wData_reg    <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BUS_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awTaken_reg <= 1'b1;
        awAddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wTaken_reg <= 1'b1;
        wData_reg  <= s_axi_wdata;
      end
      if (doWrite) begin
        awTaken_reg  <= 1'b0;
        wTaken_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // a new instruction while one is running is refused
        if ((awAddr_reg == `OFS_INSTR && state_reg != ST_READY) ||
            (awAddr_reg > `OFS_PORT))
          s_axi_bresp <= `BUS_SLVERR;
        else
          s_axi_bresp <= `BUS_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ***************************************
  // read channel
  // ***************************************
  always @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `BUS_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `BUS_OKAY;
      case (s_axi_araddr)
        `OFS_CTRL:    s_axi_rdata <= {28'h0000000, ctrl_reg};
        `OFS_INSTR:   s_axi_rdata <= {28'h0000000, op_reg};
        `OFS_ACCUM:   s_axi_rdata <= {24'h000000, ramDigit_reg, accum_reg};
        `OFS_STATUS:  s_axi_rdata <= {21'h000000, cycles_reg, skip_reg, clkLatch_reg, latchHi_reg,
                                      latchLo_reg, overflow_reg, state_reg, busy};
        `OFS_PC:      s_axi_rdata <= {21'h000000, pc_reg};
        `OFS_LOOKUP:  s_axi_rdata <= {24'h000000, lookup_reg};
        `OFS_SERIAL:  s_axi_rdata <= {20'h00000, timer_reg, serial_reg};
        `OFS_ROMADDR: s_axi_rdata <= {21'h000000, romAddr};
        `OFS_ROMDATA: s_axi_rdata <= {24'h000000, romData};
        `OFS_STACK:   s_axi_rdata <= {10'h000, stackTwo_reg, stackOne_reg};
        `OFS_PORT:    s_axi_rdata <= {24'h000000, portData_reg};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `BUS_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ***************************************
  // pulse latches; set wins over read clear
  // ***************************************
  always @(posedge clk) begin
    if (rst) begin
      latchHi_reg <= 1'b0;
      latchLo_reg <= 1'b0;
      lowHi_reg   <= 2'b11;
      lowLo_reg   <= 2'b11;
      prevHi_reg  <= 1'b1;
      prevLo_reg  <= 1'b1;
    end else begin
      prevHi_reg <= pulseInputHi;
      prevLo_reg <= pulseInputLo;
      lowHi_reg  <= {prevHi_reg, pulseInputHi};
      lowLo_reg  <= {prevLo_reg, pulseInputLo};
      if (opStart && newOp == `OP_LATCH_READ && !ctrl_reg[`CTRL_SKIP_BIT]) begin
        latchHi_reg <= 1'b0;
        latchLo_reg <= 1'b0;
      end
      if (fallHi)
        latchHi_reg <= 1'b1;
      if (fallLo)
        latchLo_reg <= 1'b1;
    end
  end

  // ***************************************
  // timer and time base, run even while idle
  // ***************************************
  always @(posedge clk) begin
    if (rst) begin
      timeBase_reg <= {TB_WIDTH{1'b0}};
      timer_reg    <= 8'h00;
      overflow_reg <= 1'b0;
    end else begin
      timeBase_reg <= timeBase_reg + 1'b1;
      timer_reg    <= timer_reg + 8'h01;
      if (opStart && !ctrl_reg[`CTRL_SKIP_BIT] && newOp == `OP_TIMER_SKIP && overflow_reg)
        overflow_reg <= 1'b0;
      if (opStart && !ctrl_reg[`CTRL_SKIP_BIT] && newOp == `OP_TIMER_LOAD) begin
        timer_reg <= {accum_reg, ramDigit_reg};
        if (accum_reg[3])
          overflow_reg <= 1'b1;
      end
      if (timeBaseCarry)
        overflow_reg <= 1'b1;
    end
  end

  // ***************************************
  // instruction sequencer
  // ***************************************
  always @(posedge clk) begin
    if (rst) begin
      state_reg      <= ST_READY;
      op_reg         <= `OP_NONE;
      pc_reg         <= `PC_RESET;
      stackOne_reg   <= `PC_RESET;
      stackTwo_reg   <= `PC_RESET;
      stackThree_reg <= `PC_RESET;
      accum_reg      <= 4'h0;
      ramDigit_reg   <= 4'h0;
      serial_reg     <= 4'h0;
      clkLatch_reg   <= 1'b0;
      lookup_reg     <= 8'h00;
      romAddr        <= `PC_RESET;
      ctrl_reg       <= 4'h0;
      portData_reg   <= 8'h00;
      skip_reg       <= 1'b0;
      cycles_reg     <= 3'd0;
    end else begin
      // serial register steps each cycle unless idle halts it
      if (state_reg != ST_IDLE) begin
        if (ctrl_reg[`CTRL_COUNT_BIT])
          serial_reg <= serial_reg + 4'h1;
        else
          serial_reg <= {serial_reg[2:0], serialIn};
      end
      if (doWrite && state_reg == ST_READY) begin
        case (awAddr_reg)
          `OFS_CTRL:   ctrl_reg <= wData_reg[3:0];
          `OFS_ACCUM: begin
            accum_reg    <= wData_reg[3:0];
            ramDigit_reg <= wData_reg[7:4];
          end
          `OFS_PC:     pc_reg <= wData_reg[10:0];
          `OFS_PORT:   portData_reg <= wData_reg[7:0];
          default:     ;
        endcase
      end
      case (state_reg)
        ST_READY: begin
          if (opStart) begin
            op_reg     <= newOp;
            cycles_reg <= 3'd1;
            skip_reg   <= 1'b0;
            // skipped ops are fetched but take one cycle
            if (ctrl_reg[`CTRL_SKIP_BIT]) begin
              pc_reg  <= pcNext;
              romAddr <= pcNext;
              ctrl_reg[`CTRL_SKIP_BIT] <= 1'b0;
            end else begin
              case (newOp)
                `OP_SERIAL_XCH: begin
                  clkLatch_reg <= ctrl_reg[`CTRL_CARRY_BIT];
                  accum_reg    <= serial_reg;
                  serial_reg   <= accum_reg;
                  pc_reg       <= pcNext;
                end
                `OP_LOOKUP: begin
                  stackOne_reg   <= pcNext;
                  stackTwo_reg   <= stackOne_reg;
                  stackThree_reg <= stackTwo_reg;
                  // page bits taken from pc+1 so last-word lookup uses next group
                  romAddr   <= {pcNext[10:8], accum_reg, ramDigit_reg};
                  state_reg <= ST_FETCH;
                end
                `OP_IND_JUMP: begin
                  romAddr   <= {pcNext[10:8], accum_reg, ramDigit_reg};
                  state_reg <= ST_FETCH;
                end
                `OP_TIMER_SKIP: begin
                  // status mirror of the pending skip, dropped when the skip is used
                  if (overflow_reg) begin
                    ctrl_reg[`CTRL_SKIP_BIT] <= 1'b1;
                    skip_reg                 <= 1'b1;
                  end
                  pc_reg <= pcNext;
                end
                `OP_IDLE: begin
                  pc_reg    <= pcNext;
                  state_reg <= ST_IDLE;
                end
                `OP_LATCH_READ: begin
                  accum_reg <= {latchHi_reg, clockPinInput, 1'b0, latchLo_reg};
                  pc_reg    <= pcNext;
                end
                `OP_PAGE_JUMP: pc_reg <= {pcNext[10:6], accum_reg[1:0], ramDigit_reg};
                `OP_PAGE2_CALL: begin
                  stackOne_reg   <= pcNext;
                  stackTwo_reg   <= stackOne_reg;
                  stackThree_reg <= stackTwo_reg;
                  pc_reg <= {5'b00010, accum_reg[1:0], ramDigit_reg};
                end
                default: pc_reg <= pcNext;
              endcase
            end
          end
        end
        ST_FETCH: begin
          cycles_reg <= 3'd2;
          state_reg  <= ST_READY;
          if (op_reg == `OP_LOOKUP) begin
            lookup_reg     <= romData;
            pc_reg         <= stackOne_reg;
            stackOne_reg   <= stackTwo_reg;
            stackTwo_reg   <= stackThree_reg;
            romAddr        <= stackOne_reg;
          end else begin
            pc_reg  <= {pcNext[10:8], romData};
            romAddr <= {pcNext[10:8], romData};
          end
        end
        ST_IDLE: begin
          // only the time-base carry wakes the core
          if (timeBaseCarry) begin
            state_reg <= ST_READY;
            romAddr   <= pc_reg;
          end
        end
        default: state_reg <= ST_READY;
      endcase
    end
  end

endmodule

// ### verilog/special_exec_map.vh
// constants for the special instruction execution block
`ifndef SPECIAL_EXEC_MAP_VH
`define SPECIAL_EXEC_MAP_VH

// register offsets (byte addresses)
`define OFS_CTRL     8'h00
`define OFS_INSTR    8'h04
`define OFS_ACCUM    8'h08
`define OFS_STATUS   8'h0C
`define OFS_PC       8'h10
`define OFS_LOOKUP   8'h14
`define OFS_SERIAL   8'h18
`define OFS_ROMADDR  8'h1C
`define OFS_ROMDATA  8'h20
`define OFS_STACK    8'h24
`define OFS_PORT     8'h28

// control fields
`define CTRL_COUNT_BIT  0
`define CTRL_CARRY_BIT  1
`define CTRL_PORTEN_BIT 2
`define CTRL_SKIP_BIT   3

// instruction codes written to the instruction register
`define OP_NONE        4'h0
`define OP_SERIAL_XCH  4'h1
`define OP_LOOKUP      4'h2
`define OP_IND_JUMP    4'h3
`define OP_TIMER_SKIP  4'h4
`define OP_TIMER_LOAD  4'h5
`define OP_IDLE        4'h6
`define OP_LATCH_READ  4'h7
`define OP_PLAIN       4'h8
`define OP_PAGE_JUMP   4'h9
`define OP_PAGE2_CALL  4'hA

// reset values, timing and bus response codes
`define PC_RESET      11'h000
`define LOW_CYCLES    2
`define BUS_OKAY      2'b00
`define BUS_SLVERR    2'b10

`endif

// ### verif/rom_model.sv
// behavioural program rom holding instructions and table data
`timescale 1ns/1ps
module rom_model (
  input  wire [10:0] romAddr,
  output wire [7:0]  romData
);
  // page bits fold into each word, so a wrong page shows up in the data
  assign romData = romAddr[7:0] ^ {romAddr[10:8], 5'h15};
endmodule

// ### verif/special_exec_chk.sv
// assertion checker on the special instruction execution ports
`timescale 1ns/1ps
`include "special_exec_map.vh"
module special_exec_chk #(
  parameter TB_WIDTH = 10
) (
  input wire        clk,
  input wire        rst,
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        serialClockLatch,
  input wire [7:0]  portOe,
  input wire        idle,
  input wire        busy
);
  // **********
  // properties
  // **********
  // idle runs for many cycles, too long for a repetition, so count it
  reg [15:0] idleCnt;
  always @(posedge clk) begin
    if (rst || !idle) idleCnt <= 16'h0000;
    else idleCnt <= idleCnt + 16'h0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wrPlain;
    wrTaken ##0 (s_axi_awaddr != `OFS_INSTR);
  endsequence
  sequence wrOp;
    wrTaken ##0 (s_axi_awaddr == `OFS_INSTR && !busy);
  endsequence
  a_oe_all_bits: assert property (portOe == 8'h00 || portOe == 8'hFF)
    else $error("port enable bits disagree");
  a_reset_clears: assert property (disable iff (1'b0)
    rst |=> !idle && !busy && portOe == 8'h00 && !serialClockLatch)
    else $error("state not cleared by reset");
  a_idle_busy: assert property (idle |-> busy)
    else $error("idle without busy");
  a_idle_bounded: assert property (idleCnt <= (16'h0001 << TB_WIDTH) + 16'h0008)
    else $error("idle outlasted time base");
  a_skl_with_op: assert property ($changed(serialClockLatch) |-> $rose(s_axi_bvalid) || $past(rst))
    else $error("clock latch moved without an op");
  a_op_starts: assert property (wrOp |-> ##2 $rose(s_axi_bvalid))
    else $error("op did not start");
  a_oe_by_write: assert property ($changed(portOe) |-> $rose(s_axi_bvalid) || $past(rst))
    else $error("port enable moved without a write");
  a_busy_start: assert property ($rose(busy) |-> $rose(s_axi_bvalid))
    else $error("op began without a write answer");
  a_fetch_short: assert property (busy && !idle |=> !busy)
    else $error("fetch cycle overran");
  a_write_answer: assert property (wrPlain |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
endmodule
bind special_instruction_execution special_exec_chk #(.TB_WIDTH(TB_WIDTH)) u_special_exec_chk (
  .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .serialClockLatch,
  .portOe, .idle, .busy);

// ### verif/tb_special_instruction_execution.sv
// self-checking bench for the special instruction execution block
`timescale 1ns/1ps
`include "special_exec_map.vh"
module tb_special_instruction_execution;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [7:0]  awAddr = 8'h00;
  reg  [31:0] wData = 32'h0;
  reg         awValid = 1'b0;
  reg         wValid = 1'b0;
  reg         bReady = 1'b0;
  reg  [7:0]  arAddr = 8'h00;
  reg         arValid = 1'b0;
  reg         rReady = 1'b0;
  reg         inHi = 1'b1;
  reg         inLo = 1'b1;
  reg         ckPin = 1'b0;
  reg         serIn = 1'b1;
  wire        awReady, wReady, bValid, arReady, rValid, idle, busy, serial_clock_latch;
  wire [1:0]  bResp, rResp;
  wire [31:0] rData;
  wire [10:0] romAddr;
  wire [7:0]  romData, portOe;
  wire        serOut;
  wire [7:0]  portOut;
  integer     failCount = 0;
  integer     numChecks = 0;
  integer     cycles = 0;
  integer     i;
  integer     busyCycles = 0;
  integer     b0, t0;
  reg  [31:0] seed = 32'h30053F94;
  reg  [31:0] rd, old;
  reg  [10:0] nx, ra;
  reg  [1:0]  resp;

  always #2.5 clk = ~clk;
  // fetch cycles seen mid-period, where busy has settled
  always @(negedge clk) if (busy && !idle) busyCycles = busyCycles + 1;

  special_instruction_execution #(.TB_WIDTH(8)) u_special_instruction_execution (
    .clk(clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .romAddr(romAddr), .romData(romData), .pulseInputHi(inHi), .pulseInputLo(inLo),
    .clockPinInput(ckPin), .serialIn(serIn), .serialOut(serOut), .serialClockLatch(serial_clock_latch),
    .portOut(portOut), .portOe(portOe), .idle(idle), .busy(busy));
  rom_model u_rom_model (.romAddr(romAddr), .romData(romData));

  // ***************
  // tasks and model
  // ***************
  function automatic [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  function automatic [7:0] romWord(input [10:0] a);
    romWord = a[7:0] ^ {a[10:8], 5'h15};
  endfunction
  task automatic check(input [127:0] what, input [31:0] e, input [31:0] g);
    begin
      numChecks = numChecks + 1;
      if (g !== e) begin
        failCount = failCount + 1;
        $display("[ERR] %0s expected %h seen %h", what, e, g);
      end
    end
  endtask
  // address and data offered together, each released when taken
  task automatic wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      awAddr <= a;
      wData <= d;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      do begin
        @(posedge clk);
        if (awValid && awReady) awValid <= 1'b0;
        if (wValid && wReady) wValid <= 1'b0;
      end while (!bValid);
      resp = bResp;
      bReady <= 1'b0;
    end
  endtask
  task automatic rdr(input [7:0] a);
    begin
      @(posedge clk);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      do begin
        @(posedge clk);
        if (arValid && arReady) arValid <= 1'b0;
      end while (!rValid);
      rd = rData;
      resp = rResp;
      rReady <= 1'b0;
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", numChecks, failCount);
      if (failCount == 0 && numChecks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // watchdog: the whole run needs well under this many cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failCount = failCount + 1;
      $display("[ERR] watchdog expected finish seen hang");
      tally_and_finish;
    end
  end

  // *********
  // scenarios
  // *********
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdr(`OFS_PC);
    check("pc reset", `PC_RESET, rd);
    rdr(`OFS_STATUS);
    check("latch reset", 32'h0, rd & 32'h30);
    wr(8'h40, 32'h1);
    check("bad write", `BUS_SLVERR, resp);
    rdr(8'h40);
    check("bad read", 32'h0, rd);
    check("bad read resp", `BUS_SLVERR, resp);
    wr(`OFS_CTRL, 32'h4);
    check("oe on", 8'hFF, portOe);
    wr(`OFS_CTRL, 32'h0);
    check("oe off", 8'h00, portOe);
    seed = xs(seed);
    wr(`OFS_PORT, {24'h0, seed[31:24]});
    check("port data", seed[31:24], portOut);
    $display("test reset and bus done");
    // lookup on even passes, indirect jump on odd; first two hit page ends
    for (i = 0; i < 10; i = i + 1) begin
      seed = xs(seed);
      nx = (i == 0) ? 11'h0FF : (i == 1) ? 11'h7FF : seed[10:0];
      wr(`OFS_PC, {21'h0, nx});
      wr(`OFS_ACCUM, {24'h0, seed[23:16]});
      b0 = busyCycles;
      wr(`OFS_INSTR, i[0] ? `OP_IND_JUMP : `OP_LOOKUP);
      check("op cycles", 1, busyCycles - b0);
      nx = nx + 11'h001;
      ra = {nx[10:8], seed[19:16], seed[23:20]};
      rdr(`OFS_PC);
      if (i[0]) check("jump pc", {nx[10:8], romWord(ra)}, rd);
      else check("lookup pc", nx, rd);
      rdr(`OFS_LOOKUP);
      if (!i[0]) check("lookup", romWord(ra), rd);
    end
    $display("test lookup and jump done");
    // wake on a carry, then spend the overflow so that only the load can set it again
    wr(`OFS_INSTR, `OP_IDLE);
    while (busy) @(negedge clk);
    wr(`OFS_INSTR, `OP_TIMER_SKIP);
    wr(`OFS_INSTR, `OP_PLAIN);
    rdr(`OFS_STATUS);
    check("overflow clear", 32'h0, rd & 32'h88);
    wr(`OFS_PC, 32'h100);
    wr(`OFS_ACCUM, 32'h08);
    wr(`OFS_INSTR, `OP_TIMER_LOAD);
    rdr(`OFS_STATUS);
    check("overflow", 32'h8, rd & 32'h8);
    wr(`OFS_INSTR, `OP_TIMER_SKIP);
    rdr(`OFS_STATUS);
    check("skip set", 32'h80, rd & 32'h88);
    rdr(`OFS_LOOKUP);
    old = rd;
    b0 = busyCycles;
    wr(`OFS_INSTR, `OP_LOOKUP);
    check("skip cycles", 0, busyCycles - b0);
    rdr(`OFS_LOOKUP);
    check("skipped lookup", old, rd);
    rdr(`OFS_PC);
    check("skip pc", 32'h103, rd);
    $display("test timer skip done");
    // hi input low long enough, lo input too short; then lo input low long enough while hi stays high
    ckPin <= seed[0];
    @(posedge clk);
    inHi <= 1'b0;
    inLo <= 1'b0;
    @(posedge clk);
    inLo <= 1'b1;
    repeat (2) @(posedge clk);
    inHi <= 1'b1;
    wr(`OFS_INSTR, `OP_LATCH_READ);
    rdr(`OFS_ACCUM);
    check("latch read", {28'h0, 1'b1, ckPin, 2'b00}, rd & 32'hF);
    inLo <= 1'b0;
    repeat (3) @(posedge clk);
    inLo <= 1'b1;
    wr(`OFS_INSTR, `OP_LATCH_READ);
    rdr(`OFS_ACCUM);
    check("latch clear", {29'h0, ckPin, 2'b01}, rd & 32'hF);
    $display("test pulse latches done");
    wr(`OFS_PC, 32'h3FF);
    wr(`OFS_INSTR, `OP_IDLE);
    while (busy) @(negedge clk);
    rdr(`OFS_PC);
    check("idle resume", 32'h400, rd);
    wr(`OFS_CTRL, 32'h2);
    repeat (4) @(posedge clk);
    check("serial out", 32'h1, serOut);
    wr(`OFS_INSTR, `OP_SERIAL_XCH);
    check("clock latch", 32'h1, serial_clock_latch);
    rdr(`OFS_ACCUM);
    check("serial stream", 32'hF, rd & 32'hF);
    // counter mode: a parked digit has counted once per cycle between two exchanges
    seed = xs(seed);
    serIn <= 1'b0;
    wr(`OFS_ACCUM, {28'h0, seed[3:0]});
    wr(`OFS_CTRL, 32'h1);
    wr(`OFS_INSTR, `OP_SERIAL_XCH);
    t0 = cycles;
    wr(`OFS_INSTR, `OP_SERIAL_XCH);
    t0 = cycles - t0 - 1;
    rdr(`OFS_ACCUM);
    check("counter mode", (seed[3:0] + t0) & 15, rd & 32'hF);
    // shift mode: the parked digit moves up one place per cycle, zeros behind it
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_ACCUM, {28'h0, seed[7:5], 1'b1});
    wr(`OFS_INSTR, `OP_SERIAL_XCH);
    t0 = cycles;
    wr(`OFS_INSTR, `OP_SERIAL_XCH);
    t0 = cycles - t0 - 1;
    rdr(`OFS_ACCUM);
    check("shift mode", ({seed[7:5], 1'b1} << t0) & 15, rd & 32'hF);
    $display("test idle and serial done");
    tally_and_finish;
  end
endmodule
